// *** dmsc_fifo.sv ***
// Setpoint FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module dmsc_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Clock, reset and flush
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_flush,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_r != DEPTH[AW:0]);
  assign o_out_valid = (count_r != '0);
  assign push        = i_in_valid && o_in_ready && !i_flush;
  assign pop         = o_out_valid && i_out_ready && !i_flush;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  // Read data straight from the storage flops
  assign o_out_data = mem_r[rd_ptr_r];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (i_flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // dmsc_fifo
`default_nettype wire

// *** dmsc_master_model.sv ***
// Master model: parameter accesses, cycle pulses and control word
`timescale 1ns/1ns
`default_nettype none
module dmsc_master_model (
  input  wire logic   i_clk,
  output logic        o_wr_en,
  output logic        o_rd_en,
  output logic [15:0] o_addr,
  output logic [31:0] o_wdata,
  output logic        o_sync,
  output logic [15:0] o_ctrl_word
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 32'h0000_0000;
    o_sync = 1'b0;
    o_ctrl_word = 16'h0000;
  end
  // Released bus shows the inverse, so stale data never looks valid
  task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_wr_en <= w;
    o_rd_en <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    access(1'b0, a, 32'h0);
  endtask
  // Gap lets the master answer promptly or slowly
  task automatic pulse(input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_sync <= 1'b1;
    @(posedge i_clk);
    o_sync <= 1'b0;
  endtask
  task automatic set_ctrl(input logic [15:0] v);
    @(posedge i_clk);
    o_ctrl_word <= v;
  endtask
endmodule // dmsc_master_model
`default_nettype wire

// *** dmsc_pkg.sv ***
// Package: constants and types for the drive mode and setpoint control block
package dmsc_pkg;

  // Parameter addresses on the parameter access port
  localparam logic [15:0] DMSC_ADDR_MODE_SEL = 16'h1B00;
  localparam logic [15:0] DMSC_ADDR_STATUS   = 16'h1B02;
  localparam logic [15:0] DMSC_ADDR_JOG_REQ  = 16'h1B12;
  localparam logic [15:0] DMSC_ADDR_VEL_SP   = 16'h1B1A;
  localparam logic [15:0] DMSC_ADDR_POS_SP   = 16'h1B1C;

  // Values after reset
  localparam logic [15:0] DMSC_RST_MODE_SEL = 16'h0000;
  localparam logic [15:0] DMSC_RST_JOG_REQ  = 16'h0000;
  localparam logic [31:0] DMSC_RST_VEL_SP   = 32'h0000_0000;
  localparam logic [31:0] DMSC_RST_POS_SP   = 32'h0000_0000;

  // Operating mode selection codes
  localparam logic [15:0] DMSC_MODE_JOG = 16'hFFFF;
  localparam logic [15:0] DMSC_MODE_CSP = 16'h0008;
  localparam logic [15:0] DMSC_MODE_CSV = 16'h0009;

  // Operating state "operation enabled"
  localparam logic [3:0] DMSC_OP_ENABLED = 4'h6;

  // Field positions
  localparam int DMSC_JOG_POS_BIT  = 0;
  localparam int DMSC_JOG_NEG_BIT  = 1;
  localparam int DMSC_JOG_FAST_BIT = 2;
  localparam logic [15:0] DMSC_JOG_MASK = 16'h0007;
  localparam int DMSC_STAT_B10 = 10;
  localparam int DMSC_STAT_B12 = 12;
  localparam logic [15:0] DMSC_CTRL_MODE_BITS = 16'h0270;

  // Interpolation timing and setpoint queue depth
  localparam int DMSC_TICK_NS = 100;
  localparam int DMSC_CLK_NS  = 10;
  localparam int DMSC_TICK_CYC = (DMSC_TICK_NS / DMSC_CLK_NS < 1) ? 1 : DMSC_TICK_NS / DMSC_CLK_NS;
  localparam int DMSC_LOG2_STEPS = 4;
  localparam int DMSC_FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    DMSC_ST_IDLE,
    DMSC_ST_CSV,
    DMSC_ST_CSP,
    DMSC_ST_JOG
  } dmsc_state_type;

  typedef struct packed {
    logic        is_pos;
    logic [31:0] value;
  } dmsc_sp_word_type;

  typedef struct packed {
    logic active;
    logic dir_pos;
    logic dir_neg;
    logic fast;
  } dmsc_jog_cmd_type;

endpackage

// *** dmsc_props.sv ***
// Checker: timing and value relations at the mode block ports
`timescale 1ns/1ns
`default_nettype none
module dmsc_props
  import dmsc_pkg::*;
(
  // Clock, reset and inputs
  input wire logic               I_MCLK,
  input wire logic               I_RSTN,
  input wire logic               I_RD_EN,
  input wire logic [3:0]         I_OP_STATE,
  input wire logic [15:0]        I_CTRL_WORD,
  input wire logic               I_HALT,
  input wire logic               I_QUICK_STOP,
  input wire logic               I_FAULT,
  input wire logic [30:0]        I_CTRL_VMAX,
  input wire logic [30:0]        I_RAMP_VMAX,
  // Outputs watched
  input wire logic [31:0]        O_RDATA,
  input wire logic               O_RD_VALID,
  input wire logic [1:0]         O_ACTIVE_MODE,
  input wire logic signed [31:0] O_VEL_CMD,
  input wire logic               O_VEL_CMD_VALID,
  input wire logic               O_POS_CMD_VALID,
  input wire dmsc_jog_cmd_type   O_JOG_CMD,
  input wire logic [15:0]        O_STATUS_WORD,
  input wire logic               O_CTRL_BITS_ERR
);
  default clocking dc @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);

  logic signed [31:0] vlim;
  logic               cyc_mode;
  // Velocity bound is the tighter of the two limits
  assign vlim = {1'b0, (I_CTRL_VMAX < I_RAMP_VMAX) ? I_CTRL_VMAX : I_RAMP_VMAX};
  assign cyc_mode = (O_ACTIVE_MODE == 2'h1) || (O_ACTIVE_MODE == 2'h2);

  AST_RD_ANSWER: assert property (I_RD_EN |=> O_RD_VALID)
    else $error("read strobe not answered next cycle");
  AST_RD_IDLE: assert property (!$past(I_RD_EN) |-> !O_RD_VALID && O_RDATA == 32'h0)
    else $error("read data shown without a read");
  AST_VEL_LIMIT: assert property (O_VEL_CMD <= vlim && O_VEL_CMD >= -vlim)
    else $error("velocity command beyond limit");
  AST_STAT_B10: assert property (O_STATUS_WORD[DMSC_STAT_B10] == 1'b0)
    else $error("status bit 10 set");
  AST_STAT_B12_SRC: assert property (O_STATUS_WORD[DMSC_STAT_B12] |-> cyc_mode && (O_VEL_CMD_VALID || O_POS_CMD_VALID))
    else $error("status bit 12 without a fed setpoint");
  AST_JOG_STAT: assert property (O_ACTIVE_MODE == 2'h3 |-> O_STATUS_WORD[DMSC_STAT_B12] == 1'b0)
    else $error("status bit 12 set in jog");
  AST_CYC_START: assert property ($changed(O_ACTIVE_MODE) && cyc_mode |-> $past(I_OP_STATE) == DMSC_OP_ENABLED)
    else $error("cyclic mode began outside state 6");
  AST_CYC_END: assert property (cyc_mode && I_OP_STATE != DMSC_OP_ENABLED |-> ##[1:3] O_ACTIVE_MODE == 2'h0)
    else $error("cyclic mode kept after leaving state 6");
  AST_JOG_STOP: assert property (I_HALT || I_QUICK_STOP || I_FAULT |-> ##[1:2] !O_JOG_CMD.active)
    else $error("jog still active after a stop");
  AST_JOG_DIRS: assert property (!(O_JOG_CMD.dir_pos && O_JOG_CMD.dir_neg))
    else $error("both jog directions commanded");
  AST_CTRL_OK: assert property (((I_CTRL_WORD & DMSC_CTRL_MODE_BITS) == 16'h0000) [*2] |-> !O_CTRL_BITS_ERR)
    else $error("control bit error with clean control word");
endmodule // dmsc_props

bind dmsc_top dmsc_props i_props (.I_MCLK, .I_RSTN, .I_RD_EN, .I_OP_STATE, .I_CTRL_WORD, .I_HALT,
  .I_QUICK_STOP, .I_FAULT, .I_CTRL_VMAX, .I_RAMP_VMAX, .O_RDATA, .O_RD_VALID, .O_ACTIVE_MODE,
  .O_VEL_CMD, .O_VEL_CMD_VALID, .O_POS_CMD_VALID, .O_JOG_CMD, .O_STATUS_WORD, .O_CTRL_BITS_ERR);
`default_nettype wire

// *** dmsc_top.sv ***
// Operating-mode logic: cyclic velocity, cyclic position and jog
//
// Contract
// - In cyclic velocity mode the drive follows per-cycle velocity setpoints, linearly interpolated between them.
// - In cyclic position mode the drive follows per-cycle position setpoints, linearly interpolated between them.
// - The master picks the mode through the mode-select parameter and the drive runs the mode taken from it.
// - Both cyclic modes begin only when the drive enters operating state 6, operation enabled.
// - The velocity setpoint is signed 32-bit, read/write, zero by default, clamped to both velocity limits before use.
// - The position setpoint is signed 32-bit, read/write, limited by the scaling range and enabled software limits.
// - Writes to the velocity setpoint, position setpoint or jog request take effect at once without a commit; the code queues setpoint writes until I_SYNC.
// - In cyclic velocity mode status bit 12 shows whether the setpoint feeds the velocity loop; bit 10 is reserved.
// - In cyclic position mode status bit 12 shows whether the setpoint feeds the position loop; bit 10 is reserved.
// - A cyclic mode ends when another mode is selected or when operating state 6 is left.
// - Jog starts as soon as jog is written to the mode select, without waiting for a state change.
// - The jog request is 16-bit, range 0 to 7: bit 0 positive, bit 1 negative, bit 2 fast speed.
// - In jog mode status bits 10 and 12 are reserved and carry nothing.
// - Jog ends when the request becomes zero, on halt or quick stop, or on a detected error.
`timescale 1ns/1ns
`default_nettype none
module dmsc_top
  import dmsc_pkg::*;
#(
  parameter int LOG2_STEPS = dmsc_pkg::DMSC_LOG2_STEPS,
  parameter int TICK_CYC   = dmsc_pkg::DMSC_TICK_CYC,
  parameter int FIFO_DEPTH = dmsc_pkg::DMSC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                       I_MCLK,
  input  wire logic                       I_RSTN,
  // Parameter access port
  input  wire logic                       I_WR_EN,
  input  wire logic                       I_RD_EN,
  input  wire logic [15:0]                I_ADDR,
  input  wire logic [31:0]                I_WDATA,
  output logic [31:0]                     O_RDATA,
  output logic                            O_RD_VALID,
  output logic                            O_SP_READY,
  // Master cycle and drive state
  input  wire logic                       I_SYNC,
  input  wire logic [3:0]                 I_OP_STATE,
  input  wire logic [15:0]                I_CTRL_WORD,
  input  wire logic                       I_HALT,
  input  wire logic                       I_QUICK_STOP,
  input  wire logic                       I_FAULT,
  // Limits
  input  wire logic [30:0]                I_CTRL_VMAX,
  input  wire logic [30:0]                I_RAMP_VMAX,
  input  wire logic signed [31:0]         I_POS_MIN,
  input  wire logic signed [31:0]         I_POS_MAX,
  input  wire logic                       I_SWLIM_EN,
  input  wire logic signed [31:0]         I_SWLIM_NEG,
  input  wire logic signed [31:0]         I_SWLIM_POS,
  // Commands to the control loops
  output logic [1:0]                      O_ACTIVE_MODE,
  output logic signed [31:0]              O_VEL_CMD,
  output logic                            O_VEL_CMD_VALID,
  output logic signed [31:0]              O_POS_CMD,
  output logic                            O_POS_CMD_VALID,
  output dmsc_pkg::dmsc_jog_cmd_type      O_JOG_CMD,
  output logic [15:0]                     O_STATUS_WORD,
  output logic                            O_CTRL_BITS_ERR
);
  import dmsc_pkg::*;

  localparam int STEPS = 2 ** LOG2_STEPS;
  localparam int TW    = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  if (LOG2_STEPS < 1 || LOG2_STEPS > 8 || TICK_CYC < 1) begin : g_chk
    $error("LOG2_STEPS must be 1..8 and TICK_CYC at least 1");
  end

  // Parameters held by the block
  logic [15:0]     mode_sel_r;
  logic [15:0]     jog_req_r;
  logic [31:0]     vel_sp_r;
  logic [31:0]     pos_sp_r;
  dmsc_state_type  state_r;
  dmsc_state_type  state_nxt;
  logic            op_en_d_r;
  logic            op_entry;
  logic            op_en;
  logic            jog_stop_r;

  // FIFO
  dmsc_sp_word_type fifo_in;
  dmsc_sp_word_type fifo_out;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic             fifo_flush;

  // Interpolator
  logic [TW-1:0]        tick_cnt_r;
  logic                 tick;
  logic [7:0]           step_cnt_r;
  logic                 interp_run_r;
  logic                 have_sp_r;
  logic signed [31:0]   interp_r;
  logic signed [31:0]   target_r;
  logic signed [31:0]   inc_r;
  logic signed [31:0]   clamped;
  logic signed [32:0]   delta;
  logic signed [32:0]   vlim;
  logic signed [31:0]   pmin;
  logic signed [31:0]   pmax;
  logic                 sp_match;
  logic                 take;

  assign op_en    = (I_OP_STATE == DMSC_OP_ENABLED);
  assign op_entry = op_en && !op_en_d_r;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_sel_r <= DMSC_RST_MODE_SEL;
      jog_req_r  <= DMSC_RST_JOG_REQ;
      vel_sp_r   <= DMSC_RST_VEL_SP;
      pos_sp_r   <= DMSC_RST_POS_SP;
    end else if (I_WR_EN) begin
      if (I_ADDR == DMSC_ADDR_MODE_SEL) begin
        mode_sel_r <= I_WDATA[15:0];
      end else if (I_ADDR == DMSC_ADDR_JOG_REQ) begin
        jog_req_r <= I_WDATA[15:0] & DMSC_JOG_MASK;
      end else if (I_ADDR == DMSC_ADDR_VEL_SP) begin
        vel_sp_r <= I_WDATA;
      end else if (I_ADDR == DMSC_ADDR_POS_SP) begin
        pos_sp_r <= I_WDATA;
      end
    end
  end

  // Setpoint writes also queue for the next master cycle
  assign fifo_in.is_pos = (I_ADDR == DMSC_ADDR_POS_SP);
  assign fifo_in.value  = I_WDATA;
  assign fifo_in_valid  = I_WR_EN && ((I_ADDR == DMSC_ADDR_VEL_SP) || (I_ADDR == DMSC_ADDR_POS_SP));
  // Stale setpoints are dropped when no cyclic mode runs
  assign fifo_flush     = (state_r != DMSC_ST_CSV) && (state_r != DMSC_ST_CSP);
  assign fifo_out_ready = I_SYNC;

  dmsc_fifo #(
    .WIDTH($bits(dmsc_sp_word_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (I_MCLK),
    .i_rst_n    (I_RSTN),
    .i_flush    (fifo_flush),
    .i_in_valid (fifo_in_valid),
    .o_in_ready (fifo_in_ready),
    .i_in_data  (fifo_in),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data (fifo_out)
  );

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      op_en_d_r <= 1'b0;
    end else begin
      op_en_d_r <= op_en;
    end
  end

  // halt, quick stop or error holds jog off until request clears
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      jog_stop_r <= 1'b0;
    end else if (I_HALT || I_QUICK_STOP || I_FAULT) begin
      jog_stop_r <= 1'b1;
    end else if (jog_req_r == 16'h0000) begin
      jog_stop_r <= 1'b0;
    end
  end

  // Mode sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DMSC_ST_IDLE: begin
        // jog starts on the mode write
        if (mode_sel_r == DMSC_MODE_JOG) begin
          state_nxt = DMSC_ST_JOG;
        // cyclic modes start on entry to state 6
        end else if (op_entry && mode_sel_r == DMSC_MODE_CSV) begin
          state_nxt = DMSC_ST_CSV;
        end else if (op_entry && mode_sel_r == DMSC_MODE_CSP) begin
          state_nxt = DMSC_ST_CSP;
        end
      end
      // cyclic modes end on mode change or leaving state 6
      DMSC_ST_CSV: begin
        if (mode_sel_r != DMSC_MODE_CSV || !op_en) begin
          state_nxt = DMSC_ST_IDLE;
        end
      end
      DMSC_ST_CSP: begin
        if (mode_sel_r != DMSC_MODE_CSP || !op_en) begin
          state_nxt = DMSC_ST_IDLE;
        end
      end
      DMSC_ST_JOG: begin
        if (mode_sel_r != DMSC_MODE_JOG) begin
          state_nxt = DMSC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = DMSC_ST_IDLE;
      end
    endcase
  end

  // mode taken from the select parameter
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_r <= DMSC_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // clamp to the smaller velocity limit
  assign vlim = (I_CTRL_VMAX < I_RAMP_VMAX) ? {2'b00, I_CTRL_VMAX} : {2'b00, I_RAMP_VMAX};
  // scaling range narrowed by enabled software limits
  assign pmin = (I_SWLIM_EN && I_SWLIM_NEG > I_POS_MIN) ? I_SWLIM_NEG : I_POS_MIN;
  assign pmax = (I_SWLIM_EN && I_SWLIM_POS < I_POS_MAX) ? I_SWLIM_POS : I_POS_MAX;

  always_comb begin
    clamped = $signed(fifo_out.value);
    if (fifo_out.is_pos) begin
      if ($signed(fifo_out.value) > pmax) begin
        clamped = pmax;
      end else if ($signed(fifo_out.value) < pmin) begin
        clamped = pmin;
      end
    end else begin
      if ($signed({fifo_out.value[31], fifo_out.value}) > vlim) begin
        clamped = vlim[31:0];
      end else if ($signed({fifo_out.value[31], fifo_out.value}) < -vlim) begin
        clamped = 32'(-vlim);
      end
    end
  end

  // Interpolation tick divider
  assign tick = (tick_cnt_r == TW'(TICK_CYC - 1));
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tick_cnt_r <= '0;
    end else if (tick || I_SYNC) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // A setpoint of the other kind is ignored
  assign sp_match = (fifo_out.is_pos == (state_r == DMSC_ST_CSP));
  assign take     = I_SYNC && fifo_out_valid && sp_match
                    && (state_r == DMSC_ST_CSV || state_r == DMSC_ST_CSP);
  assign delta    = {clamped[31], clamped} - {interp_r[31], interp_r};

  // linear interpolation in STEPS steps, one per tick, toward each taken setpoint after the first
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      interp_r     <= 32'sh0000_0000;
      target_r     <= 32'sh0000_0000;
      inc_r        <= 32'sh0000_0000;
      step_cnt_r   <= 8'h00;
      interp_run_r <= 1'b0;
      have_sp_r    <= 1'b0;
    end else if (fifo_flush) begin
      interp_run_r <= 1'b0;
      have_sp_r    <= 1'b0;
    end else if (take) begin
      target_r   <= clamped;
      step_cnt_r <= 8'h00;
      have_sp_r  <= 1'b1;
      if (!have_sp_r) begin
        // First setpoint of a mode is applied directly
        interp_r     <= clamped;
        interp_run_r <= 1'b0;
      end else begin
        inc_r        <= 32'(delta >>> LOG2_STEPS);
        interp_run_r <= 1'b1;
      end
    end else if (interp_run_r && tick) begin
      if (step_cnt_r == 8'(STEPS - 1)) begin
        interp_r     <= target_r;
        interp_run_r <= 1'b0;
      end else begin
        interp_r   <= interp_r + inc_r;
        step_cnt_r <= step_cnt_r + 1'b1;
      end
    end
  end

  // Loop commands and status
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_ACTIVE_MODE   <= 2'h0;
      O_VEL_CMD       <= 32'sh0000_0000;
      O_VEL_CMD_VALID <= 1'b0;
      O_POS_CMD       <= 32'sh0000_0000;
      O_POS_CMD_VALID <= 1'b0;
      O_STATUS_WORD   <= 16'h0000;
      O_SP_READY      <= 1'b0;
      O_CTRL_BITS_ERR <= 1'b0;
    end else begin
      O_ACTIVE_MODE   <= state_r;
      O_SP_READY      <= fifo_in_ready;
      O_VEL_CMD       <= (state_r == DMSC_ST_CSV) ? interp_r : 32'sh0000_0000;
      O_VEL_CMD_VALID <= (state_r == DMSC_ST_CSV) && have_sp_r;
      O_POS_CMD       <= (state_r == DMSC_ST_CSP) ? interp_r : 32'sh0000_0000;
      O_POS_CMD_VALID <= (state_r == DMSC_ST_CSP) && have_sp_r;
      O_STATUS_WORD   <= 16'h0000;
      // bit 12 shows setpoint in use, bit 10 reserved
      O_STATUS_WORD[DMSC_STAT_B12] <= (state_r == DMSC_ST_CSV || state_r == DMSC_ST_CSP) && have_sp_r;
      // flag master setting reserved control bits while a mode is active (not in idle)
      O_CTRL_BITS_ERR <= (state_r != DMSC_ST_IDLE) && ((I_CTRL_WORD & DMSC_CTRL_MODE_BITS) != 16'h0000);
    end
  end

  // Jog commands
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_JOG_CMD <= '0;
    end else begin
      O_JOG_CMD <= '0;
      // stop on zero request, halt, quick stop or error
      if (state_r == DMSC_ST_JOG && !jog_stop_r && !I_HALT && !I_QUICK_STOP && !I_FAULT) begin
        // bit 0 positive, bit 1 negative, bit 2 fast
        if (jog_req_r[DMSC_JOG_POS_BIT] ^ jog_req_r[DMSC_JOG_NEG_BIT]) begin
          O_JOG_CMD.active  <= 1'b1;
          O_JOG_CMD.dir_pos <= jog_req_r[DMSC_JOG_POS_BIT];
          O_JOG_CMD.dir_neg <= jog_req_r[DMSC_JOG_NEG_BIT];
          O_JOG_CMD.fast    <= jog_req_r[DMSC_JOG_FAST_BIT];
        end
      end
    end
  end

  // Parameter reads, unmapped addresses read zero
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RDATA    <= 32'h0000_0000;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_RD_EN;
      if (!I_RD_EN) begin
        O_RDATA <= 32'h0000_0000;
      end else if (I_ADDR == DMSC_ADDR_MODE_SEL) begin
        O_RDATA <= {16'h0000, mode_sel_r};
      end else if (I_ADDR == DMSC_ADDR_STATUS) begin
        O_RDATA <= {16'h0000, O_STATUS_WORD};
      end else if (I_ADDR == DMSC_ADDR_JOG_REQ) begin
        O_RDATA <= {16'h0000, jog_req_r};
      end else if (I_ADDR == DMSC_ADDR_VEL_SP) begin
        O_RDATA <= vel_sp_r;
      end else if (I_ADDR == DMSC_ADDR_POS_SP) begin
        O_RDATA <= pos_sp_r;
      end else begin
        O_RDATA <= 32'h0000_0000;
      end
    end
  end
endmodule // dmsc_top
`default_nettype wire

// *** test_drive_mode_setpoint_control.sv ***
// Testbench: parameter access, cyclic modes, jog and setpoint queue
`timescale 1ns/1ns
`default_nettype none
module test_drive_mode_setpoint_control;
  import dmsc_pkg::*;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               wr_en, rd_en, sync_p, rd_valid, sp_ready, vel_v, pos_v, ctrl_err;
  logic [15:0]        addr, ctrl, status;
  logic [31:0]        wdata, rdata;
  logic [3:0]         op_state = 4'h0;
  logic               halt = 1'b0, qstop = 1'b0, fault = 1'b0, swlim_en = 1'b0;
  logic [30:0]        cvmax = 31'd1000, rvmax = 31'd700;
  logic signed [31:0] vel, pos, lim, slim = 32'sd500, sp[9];
  logic [1:0]         mode;
  dmsc_jog_cmd_type   jog;
  logic [31:0]        exp_q[$], jreq[3] = '{32'h1, 32'h6, 32'h5}, jexp[3] = '{32'hC, 32'hB, 32'hD};
  int                 n_errors = 0, checks_done = 0, seed = 31301, i, bits[4] = '{4, 5, 6, 9};

  always #5 clk = ~clk;

  dmsc_master_model i_master (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata), .o_sync(sync_p), .o_ctrl_word(ctrl));

  dmsc_top #(.LOG2_STEPS(1), .TICK_CYC(1)) i_dut (.I_MCLK(clk), .I_RSTN(rst_n),
    .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
    .O_RD_VALID(rd_valid), .O_SP_READY(sp_ready), .I_SYNC(sync_p), .I_OP_STATE(op_state),
    .I_CTRL_WORD(ctrl), .I_HALT(halt), .I_QUICK_STOP(qstop), .I_FAULT(fault),
    .I_CTRL_VMAX(cvmax), .I_RAMP_VMAX(rvmax), .I_POS_MIN(-32'sd100000), .I_POS_MAX(32'sd100000),
    .I_SWLIM_EN(swlim_en), .I_SWLIM_NEG(-slim), .I_SWLIM_POS(slim),
    .O_ACTIVE_MODE(mode), .O_VEL_CMD(vel), .O_VEL_CMD_VALID(vel_v), .O_POS_CMD(pos),
    .O_POS_CMD_VALID(pos_v), .O_JOG_CMD(jog), .O_STATUS_WORD(status), .O_CTRL_BITS_ERR(ctrl_err));

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_master.rd(a);
    cyc(1);
  endtask
  task automatic st(input logic [3:0] v);
    @(posedge clk);
    op_state <= v;
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int k;
    for (k = 0; k < 10 && mode !== m; k++) cyc(1);
    check("mode", 32'(mode), 32'(m));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Read answers are matched against the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("extra_read", 32'h1, 32'h0);
      else check("rdata", rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    check("watchdog", 32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    {cvmax, rvmax} <= {31'd640 + 31'($random(seed) & 32'h3F), 31'd640 + 31'($random(seed) & 32'h3F)};
    cyc(2);
    check("sp_ready", 32'(sp_ready), 32'h1);
    rd(DMSC_ADDR_MODE_SEL, 32'h0);
    rd(DMSC_ADDR_VEL_SP, 32'h0);
    rd(16'h1B04, 32'h0);
    i_master.wr(DMSC_ADDR_POS_SP, 32'h8000_0001);
    rd(DMSC_ADDR_POS_SP, 32'h8000_0001);
    i_master.wr(DMSC_ADDR_JOG_REQ, 32'h0000_FFFF);
    rd(DMSC_ADDR_JOG_REQ, 32'h7);
    i_master.wr(DMSC_ADDR_JOG_REQ, 32'h0);
    $display("test registers done");
    i_master.wr(DMSC_ADDR_MODE_SEL, 32'(DMSC_MODE_CSV));
    st(DMSC_OP_ENABLED);
    wait_mode(2'h1);
    i_master.wr(DMSC_ADDR_VEL_SP, 32'd100);
    i_master.pulse(0);
    cyc(1);
    check("vel", vel, 32'd100);
    check("stat", 32'(status & 16'h1400), 32'h1000);
    for (i = 0; i < 9; i++) begin
      sp[i] = $random(seed) % 600;
      i_master.wr(DMSC_ADDR_VEL_SP, sp[i]);
    end
    cyc(1);
    check("sp_ready", 32'(sp_ready), 32'h0);
    for (i = 0; i < 8; i++) begin
      i_master.pulse(i % 3);
      cyc(8);
      check("vel", vel, sp[i]);
    end
    lim = {1'b0, (cvmax < rvmax) ? cvmax : rvmax};
    for (i = 0; i < 2; i++) begin
      i_master.wr(DMSC_ADDR_VEL_SP, i ? -32'sd5000 : 32'sd5000);
      i_master.pulse(0);
      cyc(8);
      check("vel_clamp", vel, i ? -lim : lim);
    end
    rd(DMSC_ADDR_VEL_SP, -32'sd5000);
    st(4'h0);
    wait_mode(2'h0);
    check("vel_off", vel, 32'h0);
    $display("test velocity done");
    i_master.wr(DMSC_ADDR_MODE_SEL, 32'(DMSC_MODE_CSP));
    st(DMSC_OP_ENABLED);
    wait_mode(2'h2);
    i_master.wr(DMSC_ADDR_POS_SP, 32'd200);
    i_master.pulse(0);
    cyc(1);
    check("pos", pos, 32'd200);
    check("stat", 32'(status & 16'h1400), 32'h1000);
    @(posedge clk) {swlim_en, slim} <= {1'b1, 32'sd400 + 32'($random(seed) & 32'hFF)};
    i_master.wr(DMSC_ADDR_POS_SP, 32'd900);
    i_master.pulse(0);
    cyc(8);
    check("pos_lim", pos, slim);
    i_master.wr(DMSC_ADDR_MODE_SEL, 32'(DMSC_MODE_CSV));
    wait_mode(2'h0);
    st(4'h0);
    st(DMSC_OP_ENABLED);
    wait_mode(2'h1);
    foreach (bits[b]) begin
      i_master.set_ctrl(16'h0001 << bits[b]);
      cyc(3);
      check("ctrl_err", 32'(ctrl_err), 32'h1);
      i_master.set_ctrl(16'h0000);
      cyc(3);
      check("ctrl_err", 32'(ctrl_err), 32'h0);
    end
    st(4'h0);
    wait_mode(2'h0);
    $display("test position done");
    i_master.wr(DMSC_ADDR_MODE_SEL, 32'(DMSC_MODE_JOG));
    wait_mode(2'h3);
    for (i = 0; i < 3; i++) begin
      i_master.wr(DMSC_ADDR_JOG_REQ, jreq[i]);
      cyc(2);
      check("jog", {28'h0, jog}, jexp[i]);
    end
    check("stat", 32'(status & 16'h1400), 32'h0);
    i_master.wr(DMSC_ADDR_JOG_REQ, 32'h3);
    cyc(2);
    check("jog_dirs", 32'({jog.dir_pos, jog.dir_neg}), 32'h0);
    for (i = 0; i < 3; i++) begin
      i_master.wr(DMSC_ADDR_JOG_REQ, 32'h0);
      i_master.wr(DMSC_ADDR_JOG_REQ, 32'h1);
      cyc(2);
      check("jog_on", 32'(jog.active), 32'h1);
      @(posedge clk) {fault, qstop, halt} <= 3'b001 << i;
      cyc(2);
      check("jog_stop", 32'(jog.active), 32'h0);
      @(posedge clk) {fault, qstop, halt} <= 3'b000;
      cyc(3);
      check("jog_latch", 32'(jog.active), 32'h0);
    end
    i_master.wr(DMSC_ADDR_JOG_REQ, 32'h0);
    i_master.wr(DMSC_ADDR_JOG_REQ, 32'h1);
    i_master.wr(DMSC_ADDR_JOG_REQ, 32'h0);
    cyc(2);
    check("jog_zero", 32'(jog.active), 32'h0);
    i_master.wr(DMSC_ADDR_MODE_SEL, 32'h0);
    wait_mode(2'h0);
    $display("test jog done");
    cyc(3);
    check("reads_left", 32'(exp_q.size()), 32'h0);
    end_of_test();
  end
endmodule // test_drive_mode_setpoint_control
`default_nettype wire
